// *** sfsp_defs.vh ***
// Constants for the serial-flash status and protection front end.
// Assumes inclusion by bare name from the one design file.
`ifndef SFSP_DEFS_VH
`define SFSP_DEFS_VH
`define SFSP_OP_WREN 8'h06
`define SFSP_OP_WRDI 8'h04
`define SFSP_OP_RDSR 8'h05
`define SFSP_OP_STATUS_WRITE_COMMAND 8'h01
`define SFSP_OP_READ 8'h03
`define SFSP_OP_FAST 8'h0b
`define SFSP_OP_DUAL 8'h3b
`define SFSP_OP_PP 8'h02
`define SFSP_OP_FPP 8'hf2
`define SFSP_OP_SE 8'h20
`define SFSP_OP_BE32 8'h52
`define SFSP_OP_BE64 8'hd8
`define SFSP_OP_CE1 8'h60
`define SFSP_OP_CE2 8'hc7
`define SFSP_OP_DPD 8'hb9
`define SFSP_OP_RDP 8'hab
`define SFSP_BIT_LOCK 7
`define SFSP_BIT_RHI 4
`define SFSP_BIT_RLO 2
`define SFSP_BIT_WEL 1
`define SFSP_BIT_BUSY 0
`define SFSP_SECT_MASK 24'hfff000
`define SFSP_HALF_MASK 24'hff8000
`define SFSP_BLK_MASK 24'hff0000
`define SFSP_TOP_ADDR 24'h0fffff
`define SFSP_P1 24'h0fdfff
`define SFSP_P2 24'h0fbfff
`define SFSP_P3 24'h0f7fff
`define SFSP_P4 24'h0effff
`define SFSP_P5 24'h0dffff
`define SFSP_P6 24'h0bffff
`define SFSP_WR_US 700
`endif

// *** sfsp_status_protect.v ***
// Serial-flash front end: select gating, status register, protection.
// Assumes the pins are asynchronous to clk and the array sits outside.
`timescale 1ns/1ps
`default_nettype none
`include "sfsp_defs.vh"
module sfsp_status_protect #(
  parameter CLK_MHZ = 40,
  parameter WR_CYC = `SFSP_WR_US * CLK_MHZ
) (
  input wire clk,
  input wire rstn,
  input wire por_ok,
  input wire sclk,
  input wire cs_n,
  input wire wp_n,
  input wire dual_lane_0_i,
  output reg dual_lane_0_o,
  output reg dual_lane_0_oe,
  input wire dual_lane_1_i,
  output reg dual_lane_1_o,
  output reg dual_lane_1_oe,
  output reg standby,
  output reg deep_pd,
  output reg [7:0] status_q,
  output reg wr_req,
  output reg [7:0] wr_op,
  output reg [23:0] wr_addr,
  output reg rd_req,
  output reg [23:0] rd_addr
);
  // States of the command engine
  localparam S_CMD = 3'd0;
  localparam S_ADDR = 3'd1;
  localparam S_DATA = 3'd2;
  localparam S_OUT = 3'd3;
  localparam S_SKIP = 3'd4;
  // Synchronisers for pins
  // Every pin but clk, rstn and the unused dual_lane_1_i is sampled twice on clk before any logic looks at it
  reg [1:0] sck_s, cs_s, wp_s, d0_s, por_s;
  // Previous synchronised levels, for edge detection
  reg sck_p, cs_p;
  wire sck = sck_s[1];
  wire csn = cs_s[1];
  // A link-clock edge shows about three clk cycles after the pin moves,
  // so each half period of the serial clock must span three clk or more
  wire rise = sck & ~sck_p;
  wire fall = ~sck & sck_p;
  // Engine registers
  reg armed_q; // Seen select high since reset or the last supply drop
  reg [2:0] st_q;
  reg [7:0] sh_q; // Input shift register
  reg [2:0] bc_q; // Bit count within byte
  reg [4:0] ac_q; // Address bit count
  reg [7:0] op_q;
  reg [23:0] ad_q;
  reg [7:0] ob_q; // Output shift byte
  reg dual_q;
  reg wel_q, busy_q, lock_q;
  reg [2:0] rng_q;
  reg [7:0] wsr_q; // Pending status value
  reg wsr_go_q; // Status write waiting to commit at end of busy
  // Lock, range, latch and busy together form the visible status byte
  reg [31:0] wc_q; // Write cycle counter
  reg full_q; // Input ended on byte boundary
  // Top protected address for a range code
  // Code zero is never looked up: in_prot tests the code first
  function [24:0] prot_top;
    input [2:0] r;
    begin
      case (r)
        3'd0: prot_top = 25'h1000000;
        3'd1: prot_top = {1'b0, `SFSP_P1};
        3'd2: prot_top = {1'b0, `SFSP_P2};
        3'd3: prot_top = {1'b0, `SFSP_P3};
        3'd4: prot_top = {1'b0, `SFSP_P4};
        3'd5: prot_top = {1'b0, `SFSP_P5};
        3'd6: prot_top = {1'b0, `SFSP_P6};
        default: prot_top = {1'b0, `SFSP_TOP_ADDR};
      endcase
    end
  endfunction
  // Whether the write op is one of the protected class
  function is_wr;
    input [7:0] o;
    begin
      is_wr = (o == `SFSP_OP_PP) || (o == `SFSP_OP_FPP) ||
        (o == `SFSP_OP_SE) || (o == `SFSP_OP_BE32) ||
        (o == `SFSP_OP_BE64) || (o == `SFSP_OP_CE1) ||
        (o == `SFSP_OP_CE2) || (o == `SFSP_OP_STATUS_WRITE_COMMAND);
    end
  endfunction
  // Erase/program start aligned to its unit
  wire [23:0] unit_a = (op_q == `SFSP_OP_SE) ? (ad_q & `SFSP_SECT_MASK) :
    (op_q == `SFSP_OP_BE32) ? (ad_q & `SFSP_HALF_MASK) :
    (op_q == `SFSP_OP_BE64) ? (ad_q & `SFSP_BLK_MASK) : ad_q;
  wire ce_op = (op_q == `SFSP_OP_CE1) || (op_q == `SFSP_OP_CE2);
  // Hardware protection: lock set and the protect pin held low
  wire hw_prot = lock_q & ~wp_s[1];
  // Code zero protects nothing; any other code also blocks chip erase
  wire in_prot = (rng_q != 3'd0) &&
    (({1'b0, unit_a} <= prot_top(rng_q)) || ce_op);
  wire [7:0] sr_now = {lock_q, 2'b00, rng_q, wel_q, busy_q};
  // Engine listens only when armed, selected and the supply is good
  wire act = armed_q & ~csn & por_s[1];
  // Pin synchronisers
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sck_s <= 2'b00;
      // Select reads low until the pin is really seen high, so a select
      cs_s <= 2'b00;
      wp_s <= 2'b11;
      d0_s <= 2'b00;
      por_s <= 2'b00;
      sck_p <= 1'b0;
      cs_p <= 1'b0; // held low from power-up never arms the engine
    end else begin
      sck_s <= {sck_s[0], sclk};
      cs_s <= {cs_s[0], cs_n};
      wp_s <= {wp_s[0], wp_n};
      d0_s <= {d0_s[0], dual_lane_0_i};
      por_s <= {por_s[0], por_ok};
      sck_p <= sck_s[1];
      cs_p <= cs_s[1];
    end
  end
  // Command engine and status register
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      armed_q <= 1'b0;
      st_q <= S_CMD;
      sh_q <= 8'h00;
      bc_q <= 3'd0;
      ac_q <= 5'd0;
      op_q <= 8'h00;
      ad_q <= 24'h000000;
      ob_q <= 8'h00;
      dual_q <= 1'b0;
      wel_q <= 1'b0;
      busy_q <= 1'b0;
      lock_q <= 1'b0;
      rng_q <= 3'd0;
      wsr_q <= 8'h00;
      wsr_go_q <= 1'b0;
      wc_q <= 32'd0;
      full_q <= 1'b0;
      deep_pd <= 1'b0;
      wr_req <= 1'b0;
      wr_op <= 8'h00;
      wr_addr <= 24'h000000;
      rd_req <= 1'b0;
      rd_addr <= 24'h000000;
      dual_lane_0_o <= 1'b0;
      dual_lane_0_oe <= 1'b0;
      dual_lane_1_o <= 1'b0;
      dual_lane_1_oe <= 1'b0;
      standby <= 1'b1;
      status_q <= 8'h00;
    end else if (!por_s[1]) begin
      // Below threshold: hold engine idle, state held at reset while low
      armed_q <= 1'b0;
      st_q <= S_CMD;
      // Drop any half-shifted byte so the next frame starts aligned
      bc_q <= 3'd0;
      ac_q <= 5'd0;
      full_q <= 1'b0;
      wsr_go_q <= 1'b0;
      wel_q <= 1'b0;
      busy_q <= 1'b0;
      deep_pd <= 1'b0;
      dual_lane_0_oe <= 1'b0;
      dual_lane_1_oe <= 1'b0;
      wr_req <= 1'b0;
      rd_req <= 1'b0;
      status_q <= {lock_q, 2'b00, rng_q, 2'b00};
    end else begin
      wr_req <= 1'b0;
      rd_req <= 1'b0;
      status_q <= sr_now;
      // Standby only while deselected with no write cycle running
      standby <= csn & ~busy_q;
      if (csn) begin
        armed_q <= 1'b1;
      end
      // Internal write cycle timing
      // Counter runs WR_CYC cycles; busy and latch drop together at the end
      if (busy_q) begin
        if (wc_q == 32'd0) begin
          busy_q <= 1'b0;
          wel_q <= 1'b0;
          wsr_go_q <= 1'b0;
          // Commit a pending status write unless protection came on meanwhile
          if (wsr_go_q && !hw_prot) begin
            lock_q <= wsr_q[`SFSP_BIT_LOCK];
            rng_q <= wsr_q[`SFSP_BIT_RHI:`SFSP_BIT_RLO];
          end
        end else begin
          wc_q <= wc_q - 32'd1;
        end
      end
      if (csn && !cs_p) begin
        // Frame end: act on complete write-class and power-mode frames
        dual_lane_0_oe <= 1'b0;
        dual_lane_1_oe <= 1'b0;
        st_q <= S_CMD;
        // Only whole-byte frames count, and nothing starts while busy
        if (full_q && bc_q == 3'd0 && !busy_q) begin
          // In deep power-down only the release command is heard
          if (deep_pd) begin
            if (op_q == `SFSP_OP_RDP) deep_pd <= 1'b0;
          end else if (op_q == `SFSP_OP_WREN) begin
            wel_q <= 1'b1;
          end else if (op_q == `SFSP_OP_WRDI) begin
            wel_q <= 1'b0;
          end else if (op_q == `SFSP_OP_DPD) begin
            deep_pd <= 1'b1;
          end else if (is_wr(op_q) && wel_q) begin
            if (op_q == `SFSP_OP_STATUS_WRITE_COMMAND) begin
              if (!hw_prot) begin
                busy_q <= 1'b1;
                wc_q <= WR_CYC - 1;
                wsr_go_q <= 1'b1;
              end
            end else if (!in_prot) begin
              busy_q <= 1'b1;
              wc_q <= WR_CYC - 1;
              wr_req <= 1'b1;
              wr_op <= op_q;
              wr_addr <= unit_a;
            end
          end
        end
        full_q <= 1'b0;
        bc_q <= 3'd0;
        ac_q <= 5'd0;
      end else if (act && rise && st_q != S_OUT) begin
        // Input bit on rising edge
        sh_q <= {sh_q[6:0], d0_s[1]};
        bc_q <= bc_q + 3'd1;
        if (bc_q == 3'd7) begin
          full_q <= 1'b1;
          case (st_q)
            // First byte: the command code
            S_CMD: begin
              op_q <= {sh_q[6:0], d0_s[1]};
              dual_q <= ({sh_q[6:0], d0_s[1]} == `SFSP_OP_DUAL);
              if ({sh_q[6:0], d0_s[1]} == `SFSP_OP_RDSR && !deep_pd) begin
                st_q <= S_OUT;
                ob_q <= sr_now;
              end else if (deep_pd) begin
                st_q <= S_SKIP;
              end else if ({sh_q[6:0], d0_s[1]} == `SFSP_OP_STATUS_WRITE_COMMAND) begin
                st_q <= S_DATA;
              end else begin
                st_q <= S_ADDR;
              end
            end
            // Three address bytes, most significant first
            S_ADDR: begin
              ad_q <= {ad_q[15:0], sh_q[6:0], d0_s[1]};
              ac_q <= ac_q + 5'd8;
              if (ac_q == 5'd16) begin
                rd_req <= (op_q == `SFSP_OP_READ) ||
                  (op_q == `SFSP_OP_FAST) || (op_q == `SFSP_OP_DUAL);
                rd_addr <= {ad_q[15:0], sh_q[6:0], d0_s[1]};
                st_q <= S_DATA;
              end
            end
            S_DATA: begin
              // A status value sent while busy must not disturb the pending one
              if (op_q == `SFSP_OP_STATUS_WRITE_COMMAND && !busy_q) begin
                wsr_q <= {sh_q[6:0], d0_s[1]};
              end
              // Dual read: the byte after the address is the dummy byte
              if (op_q == `SFSP_OP_DUAL) begin
                st_q <= S_OUT;
                ob_q <= 8'h00;
              end
            end
            default: st_q <= S_SKIP;
          endcase
        end else begin
          full_q <= 1'b0;
        end
      end else if (act && fall && st_q == S_OUT) begin
        // Output on falling edge; single-lane status output repeats continuously
        if (dual_q) begin
          dual_lane_1_o <= ob_q[7];
          dual_lane_0_o <= ob_q[6];
          dual_lane_1_oe <= 1'b1;
          dual_lane_0_oe <= 1'b1;
          ob_q <= {ob_q[5:0], 2'b00};
        end else begin
          // Single lane: reload the status after each byte
          dual_lane_1_o <= ob_q[7];
          dual_lane_1_oe <= 1'b1;
          ob_q <= (bc_q == 3'd7) ? sr_now : {ob_q[6:0], 1'b0};
          bc_q <= bc_q + 3'd1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** sfsp_properties.sv ***
// Checker for the serial-flash status and protection front end.
// Assumes it is bound onto sfsp_status_protect and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module sfsp_props (
  input wire clk,
  input wire rstn,
  input wire por_ok,
  input wire cs_n,
  input wire wp_n,
  input wire standby,
  input wire deep_pd,
  input wire [7:0] status_q,
  input wire wr_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_rsv; status_q[6:5] == 2'b00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved set");
  property p_stby; status_q[0] && $past(status_q[0]) |-> !standby; endproperty
  a_stby: assert property (p_stby) else $error("standby busy");
  property p_act; $fell(cs_n) ##1 (!cs_n)[*4] |-> !standby; endproperty
  a_act: assert property (p_act) else $error("not active");
  property p_busy; wr_req |-> ##[1:3] status_q[0]; endproperty
  a_busy: assert property (p_busy) else $error("no busy");
  property p_wel; $rose(status_q[0]) |-> $past(status_q[1]); endproperty
  a_wel: assert property (p_wel) else $error("busy no latch");
  property p_clr; $fell(status_q[0]) |-> ##[0:1] !status_q[1]; endproperty
  a_clr: assert property (p_clr) else $error("latch kept");
  property p_lock;
    (status_q[7] && !wp_n)[*4] |=> $stable(status_q[7:2]);
  endproperty
  a_lock: assert property (p_lock) else $error("locked bits moved");
  property p_por; (!por_ok)[*4] |-> status_q[1:0] == 2'b00; endproperty
  a_por: assert property (p_por) else $error("low supply");
  property p_prot; wr_req |-> status_q[4:2] != 3'h7; endproperty
  a_prot: assert property (p_prot) else $error("write all prot");
  property p_dpd; deep_pd |-> !wr_req; endproperty
  a_dpd: assert property (p_dpd) else $error("write in dpd");
endmodule
bind sfsp_status_protect sfsp_props chk_u (.clk(clk), .rstn(rstn),
  .por_ok(por_ok), .cs_n(cs_n), .wp_n(wp_n), .standby(standby),
  .deep_pd(deep_pd), .status_q(status_q), .wr_req(wr_req));
`default_nettype wire

// *** sfsp_host.sv ***
// Host controller model: drives select, serial clock and serial input.
// Assumes the bench resolves the lanes and feeds the answer to so.
`timescale 1ns/1ps
`default_nettype none
module sfsp_host (
  input wire clk,
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire so
);
  logic cpol; // Idle clock level, 0 mode 0, 1 mode 3
  initial begin
    cpol = 0; sclk = 0; cs_n = 1; si = 0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bytes MSB first; rx keeps the last byte seen on so
  // Bits beyond the fifth byte go out as zeros
  task automatic xfer(input [39:0] tx, input int nb, output [7:0] rx);
    cs_n = 0;
    tick(4);
    for (int i = 0; i < nb * 8; i++) begin
      sclk = 0; si = (i < 40) ? tx[39-i] : 1'b0; tick(4);
      sclk = 1; rx = {rx[6:0], so}; tick(4);
    end
    sclk = cpol; tick(4); // Clock stands at idle level
    cs_n = 1; si = ~si; tick(8); // Released line shows inverse
  endtask
endmodule
`default_nettype wire

// *** sfsp_status_protect_tb_top.sv ***
// Self-checking bench for the status and protection front end.
// Assumes the host model and checker files are compiled beforehand.
`timescale 1ns/1ps
`default_nettype none
module sfsp_status_protect_tb_top;
  logic clk = 0, rstn = 0, por_ok = 1, wp_n = 1, tog = 0;
  logic sclk, cs_n, si, l0_o, l0_oe, l1_o, l1_oe, stby, dpd, wr_req;
  logic [7:0] st, wr_op, rx;
  logic rd_req;
  logic [23:0] wr_addr, got_a, rd_addr, got_r, ra;
  logic [24:0] a;
  logic [2:0] r;
  int n_errors = 0, n_tests = 0, n_wr = 0, n_rd = 0, n_dual = 0;
  wire lane0 = l0_oe ? l0_o : si;
  wire lane1 = l1_oe ? l1_o : tog; // Undriven lane toggles
  always #12.5 clk = ~clk;
  always @(posedge clk) tog <= ~tog;
  always @(posedge clk) if (wr_req === 1'b1) begin
    n_wr <= n_wr + 1; got_a <= wr_addr;
  end
  // Read requests and cycles with both lanes driven
  always @(posedge clk) if (rd_req === 1'b1) begin
    n_rd <= n_rd + 1; got_r <= rd_addr;
  end
  always @(posedge clk) if (l0_oe === 1'b1 && l1_oe === 1'b1) begin
    n_dual <= n_dual + 1;
  end
  sfsp_host host_u (.clk(clk), .sclk(sclk), .cs_n(cs_n), .si(si),
    .so(lane1));
  sfsp_status_protect #(.WR_CYC(20)) dut_u (.clk(clk), .rstn(rstn),
    .por_ok(por_ok), .sclk(sclk), .cs_n(cs_n), .wp_n(wp_n),
    .dual_lane_0_i(lane0), .dual_lane_0_o(l0_o), .dual_lane_0_oe(l0_oe),
    .dual_lane_1_i(lane1), .dual_lane_1_o(l1_o), .dual_lane_1_oe(l1_oe),
    .standby(stby), .deep_pd(dpd), .status_q(st), .wr_req(wr_req),
    .wr_op(wr_op), .wr_addr(wr_addr), .rd_req(rd_req), .rd_addr(rd_addr));
  task automatic chk(input [23:0] got, input [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd(input [7:0] op);
    host_u.xfer({op, 32'h0}, 1, rx);
  endtask
  task automatic rd(input [7:0] exp);
    host_u.xfer({8'h05, 32'h0}, 2, rx);
    chk(24'(rx), 24'(exp));
  endtask
  task automatic idle;
    for (int i = 0; i < 100 && st[0] !== 1'b0; i++) host_u.tick(1);
    chk(24'(st[0]), 24'h0);
  endtask
  task automatic status_write_command(input [7:0] v);
    cmd(8'h06);
    host_u.xfer({8'h01, v, 24'h0}, 2, rx);
    idle;
  endtask
  // Sector erase; ok says whether the device should take it
  task automatic ers(input [23:0] ad, input bit ok);
    int n0;
    n0 = n_wr;
    cmd(8'h06);
    host_u.xfer({8'h20, ad, 8'h0}, 4, rx);
    idle;
    chk(24'(n_wr - n0), 24'(ok));
    if (ok) chk(got_a, ad & 24'hfff000);
    if (ok) chk(24'(wr_op), 24'h20);
  endtask
  // First address left writable under a range code
  function automatic [24:0] lim(input [2:0] c);
    if (c == 3'h0) lim = 25'h0;
    else if (c == 3'h7) lim = 25'h100000;
    else lim = 25'h100000 - (25'h2000 << (c - 3'h1));
  endfunction
  task automatic tally_and_finish;
    if (n_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Whole run needs well under half a millisecond
  initial begin
    #2000000;
    n_errors++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(72));
    #1 host_u.cs_n = 0;
    repeat (6) @(posedge clk);
    #1 rstn = 1;
    cmd(8'h06); // Select low from power-up, no falling edge
    rd(8'h00);
    cmd(8'h06);
    rd(8'h02);
    cmd(8'h04);
    host_u.xfer({8'h01, 8'hff, 24'h0}, 2, rx);
    rd(8'h00);
    r = 3'($urandom);
    cmd(8'h06);
    host_u.xfer({8'h01, 3'b011, r, 2'b11, 24'h0}, 2, rx);
    chk(24'(st), 24'h03);
    idle;
    chk(24'(stby), 24'h1);
    rd({3'b000, r, 2'b00});
    cmd(8'hb9);
    cmd(8'h06);
    chk(24'({dpd, st[1]}), 24'h2);
    cmd(8'hab);
    chk(24'(dpd), 24'h0);
    status_write_command(8'h84);
    wp_n = 0;
    status_write_command(8'h00);
    chk(24'(st[7:2]), 24'h21);
    wp_n = 1;
    status_write_command(8'h00);
    rd(8'h00);
    ra = 24'($urandom);
    host_u.xfer({8'h3b, ra, 8'h00}, 6, rx);
    chk(24'(n_rd), 24'h1);
    chk(got_r, ra);
    chk(24'(n_dual != 0), 24'h1);
    chk(24'(rx), 24'h00);
    chk(24'({l0_oe, l1_oe}), 24'h0);
    host_u.cpol = 1;
    host_u.sclk = 1;
    for (int c = 0; c < 8; c++) begin
      status_write_command({3'b000, 3'(c), 2'b00});
      a = lim(3'(c));
      if (a != 25'h0) ers(24'(a - 25'h1), 1'b0);
      if (a < 25'h100000) ers(24'(a + $urandom % (25'h100000 - a)), 1'b1);
    end
    cmd(8'h06);
    por_ok = 0;
    host_u.tick(10);
    chk(24'(st[1:0]), 24'h0);
    por_ok = 1;
    host_u.tick(10);
    rd(8'h1c);
    tally_and_finish;
  end
endmodule
`default_nettype wire
